/* File: rtl/adc_mode_consts.svh */
// Constants of the converter mode-programming port: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the port module.
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH
// Register addresses
`define ADDR_SOFT_RESET     7'h00
`define ADDR_POWER_DOWN     7'h01
// Field positions
`define SOFT_RESET_BIT      7
`define PD_FIELD_MSB        1
// Reset values
`define POWER_DOWN_RESET    2'h0
`define READ_IDLE_VALUE     8'h00
// Power-down field codes
`define PD_NORMAL           2'h0
`define PD_NAP              2'h1
`define PD_SLEEP            2'h3
// Serial word layout
`define WORD_BITS           5'h10
`define ADDR_DONE_BITS      5'h08
// Parallel-mode output settings: lowest LVDS current code, termination off
`define LVDS_CURRENT_PAR    3'h0
`define TERM_PAR            1'b0
// Sample-clock cycles granted after leaving nap
`define NAP_RECOVERY_CYCLES 7'h64
`endif

/* File: rtl/adc_mode_pkg.sv */
// Types shared by the converter mode-programming port.
// Assumes the constants header sits beside it.
`include "adc_mode_consts.svh"
package adc_mode_pkg;
    typedef enum logic [2:0] {
        LINK_IDLE     = 3'b001,
        LINK_SHIFT    = 3'b010,
        LINK_PARALLEL = 3'b100
    } link_state_t;
    typedef enum logic [1:0] {
        OMODE_CMOS     = 2'b00,
        OMODE_LVDS     = 2'b01,
        OMODE_DDR_CMOS = 2'b10
    } out_mode_t;
endpackage : adc_mode_pkg

/* File: rtl/adc_mode_programming_port.sv */
// Mode-programming port of a sampling converter: strap-selected parallel pins or serial port.
// Assumes all pins, the host serial clock and the sample clock are asynchronous to clk_sys.
`timescale 1ns/1ns
`include "adc_mode_consts.svh"
module adc_mode_programming_port (
    input  wire logic       clk_sys,                  // System clock, 50 MHz
    input  wire logic       rst,                      // Asynchronous reset, active high
    input  wire logic       programming_select_strap, // Strap: high parallel, low serial
    input  wire logic       cs_n,                     // Chip-select pin, active low
    input  wire logic       sck,                      // Serial clock pin
    input  wire logic       sdi,                      // Serial data input pin
    input  wire logic       sample_clk,               // Converter sample clock
    output logic            sdo_out,                  // Open-drain level, always low
    output logic            sdo_oe,                   // High while pulling the output low
    output logic            parallel_mode,            // Strap selects parallel mode
    output logic            dcs_enable,               // Duty-cycle stabilizer on
    output logic [1:0]      output_mode,              // Digital output mode
    output logic [2:0]      lvds_current,             // LVDS current code
    output logic            termination_on,           // Internal LVDS termination
    output logic            sleep_mode,               // Whole converter asleep
    output logic            nap_mode,                 // Core napping
    output logic            core_data_valid,          // Core output data valid
    output logic            soft_reset_pulse          // One cycle on software reset
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic       cs_d;
    logic       sck_d;
    logic       smp_d;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // Strap bit starts serial so no false parallel pulse follows reset
            pin_meta <= 5'h17;
            pin_sync <= 5'h17;
        end else begin
            pin_meta <= {sample_clk, programming_select_strap, cs_n, sck, sdi};
            pin_sync <= pin_meta;
        end
    end
    wire smp_s   = pin_sync[4];
    wire strap_s = pin_sync[3];
    wire cs_s    = pin_sync[2];
    wire sck_s   = pin_sync[1];
    wire sdi_s   = pin_sync[0];

    // Edge history behind the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_d  <= 1'b1;
            sck_d <= 1'b1;
            smp_d <= 1'b1;
        end else begin
            cs_d  <= cs_s;
            sck_d <= sck_s;
            smp_d <= smp_s;
        end
    end
    wire cs_fall  = cs_d & ~cs_s;
    wire cs_rise  = ~cs_d & cs_s;
    wire sck_rise = ~sck_d & sck_s;
    wire sck_fall = sck_d & ~sck_s;
    wire smp_rise = ~smp_d & smp_s;

    ////////////////////////////////////////////////////////////////////////////
    // Link state
    adc_mode_pkg::link_state_t state;
    adc_mode_pkg::link_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            adc_mode_pkg::LINK_IDLE: begin
                if (strap_s) next_state = adc_mode_pkg::LINK_PARALLEL;
                else if (cs_fall) next_state = adc_mode_pkg::LINK_SHIFT;
            end
            adc_mode_pkg::LINK_SHIFT: begin
                if (strap_s) next_state = adc_mode_pkg::LINK_PARALLEL;
                else if (cs_s) next_state = adc_mode_pkg::LINK_IDLE;
            end
            adc_mode_pkg::LINK_PARALLEL: begin
                if (!strap_s) next_state = adc_mode_pkg::LINK_IDLE;
            end
            default: next_state = adc_mode_pkg::LINK_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) state <= adc_mode_pkg::LINK_IDLE;
        else state <= next_state;
    end
    wire shifting = (state == adc_mode_pkg::LINK_SHIFT) && !strap_s && !cs_s;

    ////////////////////////////////////////////////////////////////////////////
    // Command shifter: flag, seven address bits, eight data bits
    logic [4:0]  bit_count;
    logic [15:0] cmd_word;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_count <= 5'h00;
            cmd_word  <= 16'h0000;
        end else if (!shifting) begin
            bit_count <= 5'h00;
        end else if (sck_rise && bit_count < `WORD_BITS) begin
            bit_count <= bit_count + 5'h01;
            cmd_word  <= {cmd_word[14:0], sdi_s};
        end
    end
    wire       word_full = (bit_count == `WORD_BITS);
    wire       rw_flag   = cmd_word[15];
    wire [6:0] cmd_addr  = cmd_word[14:8];
    wire [7:0] cmd_data  = cmd_word[7:0];
    // Complete write word taken on chip-select rising
    wire commit_write = cs_rise && (state == adc_mode_pkg::LINK_SHIFT)
                        && word_full && !rw_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Mode control registers
    logic [1:0] power_down;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_down       <= `POWER_DOWN_RESET;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= 1'b0;
            if (commit_write && cmd_addr == `ADDR_SOFT_RESET && cmd_data[`SOFT_RESET_BIT]) begin
                power_down       <= `POWER_DOWN_RESET;
                soft_reset_pulse <= 1'b1;
            end else if (commit_write && cmd_addr == `ADDR_POWER_DOWN) begin
                power_down <= cmd_data[`PD_FIELD_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback shifter, open-drain output
    logic [7:0] rd_shift;
    logic       rd_active;
    // Reset register reads as idle value; address sits in low bits at load time
    wire [7:0]  rd_value = (cmd_word[6:0] == `ADDR_POWER_DOWN) ?
                           {6'h00, power_down} : `READ_IDLE_VALUE;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_shift  <= 8'h00;
            rd_active <= 1'b0;
        end else if (!shifting) begin
            rd_active <= 1'b0;
        end else if (sck_rise && bit_count == `ADDR_DONE_BITS - 5'h01) begin
            rd_active <= cmd_word[6];
            rd_shift  <= 8'h00;
        end else if (rd_active && bit_count == `ADDR_DONE_BITS && rd_shift == 8'h00
                     && !sck_rise) begin
            rd_shift <= rd_value;
        end else if (sck_fall && bit_count > `ADDR_DONE_BITS) begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end
    // Drive low only for a zero bit while selected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
        end else begin
            sdo_out <= 1'b0;
            sdo_oe  <= shifting && rd_active && !rd_shift[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            parallel_mode  <= 1'b0;
            dcs_enable     <= 1'b0;
            output_mode    <= adc_mode_pkg::OMODE_CMOS;
            lvds_current   <= `LVDS_CURRENT_PAR;
            termination_on <= `TERM_PAR;
            sleep_mode     <= 1'b0;
            nap_mode       <= 1'b0;
        end else if (strap_s) begin
            parallel_mode  <= 1'b1;
            dcs_enable     <= cs_s;
            output_mode    <= sck_s ? adc_mode_pkg::OMODE_LVDS
                                    : adc_mode_pkg::OMODE_CMOS;
            lvds_current   <= `LVDS_CURRENT_PAR;
            termination_on <= `TERM_PAR;
            sleep_mode     <= sdi_s;
            nap_mode       <= 1'b0;
        end else begin
            parallel_mode  <= 1'b0;
            dcs_enable     <= 1'b0;
            output_mode    <= adc_mode_pkg::OMODE_CMOS;
            lvds_current   <= `LVDS_CURRENT_PAR;
            termination_on <= `TERM_PAR;
            sleep_mode     <= (power_down == `PD_SLEEP);
            nap_mode       <= (power_down == `PD_NAP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up recovery on the sample clock
    logic [6:0] recover_count;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            recover_count   <= 7'h00;
            core_data_valid <= 1'b0;
        end else if (sleep_mode || nap_mode) begin
            recover_count   <= 7'h00;
            core_data_valid <= 1'b0;
        end else begin
            if (smp_rise && recover_count < `NAP_RECOVERY_CYCLES)
                recover_count <= recover_count + 7'h01;
            core_data_valid <= (recover_count == `NAP_RECOVERY_CYCLES);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence reset_write_s;
        commit_write && cmd_addr == `ADDR_SOFT_RESET && cmd_data[`SOFT_RESET_BIT];
    endsequence
    sequence reset_done_s;
        power_down == `PD_NORMAL && soft_reset_pulse ##1 !soft_reset_pulse;
    endsequence

    par_dcs_a: assert property (strap_s |=> dcs_enable == $past(cs_s))
        else $error("parallel stabilizer wrong");
    par_omode_a: assert property (strap_s && sck_s |=> output_mode == 2'b01
                                  && lvds_current == 3'h0 && !termination_on)
        else $error("parallel output mode wrong");
    par_sleep_a: assert property (strap_s |=> sleep_mode == $past(sdi_s) && !nap_mode)
        else $error("parallel sleep wrong");
    par_no_shift_a: assert property (strap_s |=> bit_count == 5'h00)
        else $error("shifting in parallel mode");
    count_cap_a: assert property (sck_rise && word_full && shifting |=> word_full)
        else $error("bits past sixteen taken");
    soft_reset_a: assert property (reset_write_s |=> reset_done_s)
        else $error("software reset failed");
    write_pd_a: assert property (commit_write && cmd_addr == 7'h01 && !cmd_data[7]
                                 |=> power_down == $past(cmd_data[1:0]))
        else $error("power-down write lost");
    read_keep_a: assert property (cs_rise && rw_flag |=> $stable(power_down))
        else $error("read changed register");
    partial_drop_a: assert property (cs_rise && !word_full |=> $stable(power_down))
        else $error("partial word written");
    sdo_idle_a: assert property (cs_s |=> !sdo_oe)
        else $error("output driven while idle");
    pd_decode_a: assert property (!strap_s |=> nap_mode == ($past(power_down) == 2'h1)
                                  && sleep_mode == ($past(power_down) == 2'h3))
        else $error("power-down decode wrong");
    nap_valid_a: assert property (core_data_valid |-> recover_count == 7'd100)
        else $error("data valid too early");

    // Structure of the serial link, the readback path, the mode registers and outputs, and nap recovery
    sequence read_flag_s;
        shifting && sck_rise && bit_count == `ADDR_DONE_BITS - 5'h01 && cmd_word[6];
    endsequence

    serial_outs_a: assert property (!strap_s |=> !parallel_mode && !dcs_enable
                                    && output_mode == 2'h0)
        else $error("serial mode outputs wrong");
    par_state_a: assert property (strap_s |=> state == adc_mode_pkg::LINK_PARALLEL)
        else $error("parallel state not entered");
    frame_open_a: assert property (cs_fall && !strap_s
                                   && state == adc_mode_pkg::LINK_IDLE
                                   |=> state == adc_mode_pkg::LINK_SHIFT)
        else $error("frame not opened");
    frame_close_a: assert property (cs_rise |=> state != adc_mode_pkg::LINK_SHIFT
                                    && bit_count == 5'h00)
        else $error("frame not closed");
    read_arm_a: assert property (read_flag_s |=> rd_active)
        else $error("read not armed");
    sdo_level_a: assert property (sdo_out == 1'h0)
        else $error("output level not low");
    nap_block_a: assert property (nap_mode |=> !core_data_valid)
        else $error("data valid during nap");
    soft_clear_a: assert property (soft_reset_pulse |-> power_down == `PD_NORMAL)
        else $error("software reset left register set");
    word_cap_a: assert property (bit_count <= `WORD_BITS)
        else $error("bit count past sixteen");
    commit_len_a: assert property (commit_write |=> bit_count == 5'h00)
        else $error("bit count kept after commit");

endmodule : adc_mode_programming_port

/* File: tb/host_model.sv */
// Host controller model: frames 16-bit serial commands and reads back through a pull-up.
// Assumes the bench clock paces it; sck stands low and sdi toggles outside frames.
`timescale 1ns/1ns
module host_model (
    input  wire logic clk_sys,  // Bench clock pacing the host
    output logic      cs_n,     // Chip-select, active low
    output logic      sck,      // Serial clock, 160 ns period
    output logic      sdi,      // Serial data to the device
    input  wire logic sdo_line  // Open-drain line with pull-up
);
    // Idle levels at time zero
    initial begin
        cs_n = 1'h1;
        sck  = 1'h0;
        sdi  = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wait n clocks, then step just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // One framed command of nbits pulses; read byte sampled late in pulses 9..16
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        tick(1);
        cs_n = 1'h0;
        for (int i = 0; i < nbits; i++) begin
            tick(2);
            sdi = (i < 16) ? word[15 - i] : ~sdi;
            tick(2);
            sck = 1'h1;
            tick(4);
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
            sck = 1'h0;
        end
        tick(4);
        cs_n = 1'h1;
        sdi  = ~sdi;
        tick(8);
    endtask : xfer
endmodule : host_model

/* File: tb/testbench.sv */
// Self-checking bench of the mode-programming port, serial and parallel modes.
// Assumes host_model drives the serial pins; the bench drives them in parallel mode.
`timescale 1ns/1ns
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module testbench;
    logic       clk_sys, rst, strap, sample_clk, par_cs_n, par_sck, par_sdi;
    logic       host_cs_n, host_sck, host_sdi, sdo_out, sdo_oe, parallel_mode;
    logic       dcs_enable, termination_on, sleep_mode, nap_mode, core_data_valid;
    logic [1:0] output_mode;
    logic [2:0] lvds_current;
    logic [7:0] rd;
    logic       soft_reset_pulse;
    int         errors, tests_run, pulses;
    wire logic  sdo_line = sdo_oe ? sdo_out : 1'h1;  // External pull-up

    // Clocks: 50 MHz system, free-running sample clock
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        sample_clk = 1'h0;
        forever #20 sample_clk = ~sample_clk;
    end

    host_model host (.clk_sys(clk_sys), .cs_n(host_cs_n), .sck(host_sck), .sdi(host_sdi),
        .sdo_line(sdo_line));
    adc_mode_programming_port uut (.clk_sys(clk_sys), .rst(rst),
        .programming_select_strap(strap), .cs_n(strap ? par_cs_n : host_cs_n),
        .sck(strap ? par_sck : host_sck), .sdi(strap ? par_sdi : host_sdi),
        .sample_clk(sample_clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .parallel_mode(parallel_mode), .dcs_enable(dcs_enable), .output_mode(output_mode),
        .lvds_current(lvds_current), .termination_on(termination_on),
        .sleep_mode(sleep_mode), .nap_mode(nap_mode), .core_data_valid(core_data_valid),
        .soft_reset_pulse(soft_reset_pulse));

    // Count software-reset pulses seen by the bench
    always @(posedge clk_sys) begin
        if (soft_reset_pulse === 1'h1) pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results;
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Register write and checked read
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'h0, a, d}, 16, rd);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        host.xfer({1'h1, a, 8'hA5}, 16, rd);
        `CHECK("readback", e, rd)
        `CHECK("sdo_out", 1'h0, sdo_out)
        `CHECK("sdo_oe idle", 1'h0, sdo_oe)
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_soft_reset;
        `CHECK("parallel_mode", 1'h0, parallel_mode)
        wr(7'h00, 8'h80);
        `CHECK("soft_reset_pulse count", 1, pulses)
        rdchk(7'h00, 8'h00);
        wr(7'h01, 8'h03);
        wr(7'h00, 8'h7F);
        `CHECK("soft_reset_pulse count", 1, pulses)
        rdchk(7'h01, 8'h03);
        wr(7'h00, 8'h80);
        `CHECK("soft_reset_pulse count", 2, pulses)
        rdchk(7'h01, 8'h00);
        `CHECK("sleep_mode", 1'h0, sleep_mode)
    endtask : t_soft_reset

    task automatic t_pd_codes;
        for (int c = 0; c < 4; c++) begin
            wr(7'h01, {6'h2D, c[1:0]});
            `CHECK("sleep_mode", (c == 3), sleep_mode)
            `CHECK("nap_mode", (c == 1), nap_mode)
            rdchk(7'h01, {6'h00, c[1:0]});
        end
    endtask : t_pd_codes

    task automatic t_frames;
        rdchk(7'h01, 8'h03);
        `CHECK("sleep_mode", 1'h1, sleep_mode)
        wr(7'h01, 8'h00);
        host.xfer({1'h0, 7'h01, 8'h03}, 12, rd);
        `CHECK("sleep_mode", 1'h0, sleep_mode)
        host.xfer({1'h0, 7'h01, 8'h03}, 18, rd);
        `CHECK("sleep_mode", 1'h1, sleep_mode)
        wr(7'h05, 8'hFF);
        rdchk(7'h05, 8'h00);
        rdchk(7'h01, 8'h03);
    endtask : t_frames

    task automatic t_nap;
        wr(7'h01, 8'h01);
        `CHECK("core_data_valid", 1'h0, core_data_valid)
        wr(7'h01, 8'h00);
        repeat (85) @(posedge sample_clk);
        `CHECK("core_data_valid", 1'h0, core_data_valid)
        repeat (20) @(posedge sample_clk);
        `CHECK("core_data_valid", 1'h1, core_data_valid)
    endtask : t_nap

    task automatic t_parallel;
        @(posedge clk_sys);
        #1;
        strap = 1'h1;
        for (int v = 0; v < 8; v++) begin
            {par_cs_n, par_sck, par_sdi} = v[2:0];
            repeat (6) @(posedge clk_sys);
            #1;
            `CHECK("parallel_mode", 1'h1, parallel_mode)
            `CHECK("dcs_enable", v[2], dcs_enable)
            `CHECK("output_mode", v[1] ? 2'h1 : 2'h0, output_mode)
            `CHECK("lvds_current", 3'h0, lvds_current)
            `CHECK("termination_on", 1'h0, termination_on)
            `CHECK("sleep_mode", v[0], sleep_mode)
        end
    endtask : t_parallel

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, strap, par_cs_n, par_sck, par_sdi} = 5'h11;
        errors    = 0;
        tests_run = 0;
        pulses    = 0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        repeat (5) @(posedge clk_sys);
        #1;
        t_soft_reset();
        t_pd_codes();
        t_frames();
        t_nap();
        t_parallel();
        results();
    end

    // Watchdog
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule : testbench
